// ---- rtl/csx_core.v ----
`timescale 1ns/10ps
`include "csx_consts.vh"

module csx_core (
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  input  wire [7:0]  mod_addr_i,
  input  wire        standalone_i,
  input  wire        nv_keep_i,
  input  wire        rx_valid_i,
  input  wire        rx_first_i,
  input  wire [7:0]  rx_data_i,
  output wire        rx_ready_o,
  input  wire [31:0] act_pos_i,
  input  wire        accu_wr_i,
  input  wire [31:0] accu_wr_data_i,
  output reg  [31:0] accu_o,
  output reg  [31:0] xreg_o,
  output wire        nv_req_o,
  output wire        nv_we_o,
  output reg  [4:0]  nv_addr_o,
  output reg  [31:0] nv_wdata_o,
  input  wire        nv_ack_i,
  input  wire [31:0] nv_rdata_i,
  output reg         rep_valid_o,
  output reg  [7:0]  rep_status_o,
  output reg  [7:0]  rep_instr_o,
  output reg  [31:0] rep_value_o
);

  ////////////////////////////////////////////////////////////////////////
  // State codes
  localparam [2:0] S_BOOT  = 3'h0;
  localparam [2:0] S_RX    = 3'h1;
  localparam [2:0] S_NVRD  = 3'h2;
  localparam [2:0] S_NVLD  = 3'h3;
  localparam [2:0] S_NVWR  = 3'h4;
  localparam [2:0] S_REPLY = 3'h5;

  reg [2:0]  state;
  reg [3:0]  cnt;
  reg [7:0]  f_addr;
  reg [7:0]  f_ins;
  reg [7:0]  f_type;
  reg [7:0]  f_mot;
  reg [31:0] f_val;
  reg [7:0]  sum;
  reg [4:0]  last;
  reg        quiet;
  reg [31:0] coord [0:20];
  integer    i;

  ////////////////////////////////////////////////////////////////////////
  // Byte position and operand helpers
  wire [3:0] pos = rx_first_i ? 4'h0 : cnt;
  wire       take = (state == S_RX) && rx_valid_i;
  wire       frame_end = take && (pos == `CSX_LAST_BYTE);
  wire       bad_sel = (f_mot != 8'h00) || (f_type > `CSX_COORD_MAX);
  wire       one_ok = (f_type != 8'h00) && (f_type <= `CSX_COORD_MAX);
  wire [4:0] sel = f_type[4:0];
  wire       keep_nv = nv_keep_i && (f_type != 8'h00);

  wire signed [31:0] op_a = accu_o;
  wire signed [31:0] op_x = xreg_o;
  wire signed [63:0] prod = op_a * op_x;
  wire signed [31:0] quot = op_a / op_x;
  wire signed [31:0] rem  = op_a % op_x;
  wire               x_zero = (xreg_o == 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////
  // Second-operand arithmetic result
  reg [31:0] next_accu;
  reg [31:0] next_xreg;
  reg [7:0]  next_status;
  always @* begin
    next_accu   = accu_o;
    next_xreg   = xreg_o;
    next_status = `CSX_ST_OK;
    case (f_type)
      `CSX_OP_ADD:  next_accu = accu_o + xreg_o;
      `CSX_OP_SUB:  next_accu = accu_o - xreg_o;
      `CSX_OP_MUL:  next_accu = prod[31:0];
      `CSX_OP_DIV: begin
        if (x_zero) begin
          next_status = `CSX_ST_BAD_VAL;
        end else begin
          next_accu = quot;
        end
      end
      `CSX_OP_MOD: begin
        if (x_zero) begin
          next_status = `CSX_ST_BAD_VAL;
        end else begin
          next_accu = rem;
        end
      end
      `CSX_OP_AND:  next_accu = accu_o & xreg_o;
      `CSX_OP_OR:   next_accu = accu_o | xreg_o;
      `CSX_OP_XOR:  next_accu = accu_o ^ xreg_o;
      `CSX_OP_NOT:  next_xreg = ~xreg_o;
      `CSX_OP_LOAD: next_xreg = accu_o;
      `CSX_OP_SWAP: begin
        next_accu = xreg_o;
        next_xreg = accu_o;
      end
      default: next_status = `CSX_ST_BAD_TYPE;
    endcase
  end

  assign rx_ready_o = (state == S_RX);
  assign nv_req_o   = (state == S_NVRD) || (state == S_NVWR);
  assign nv_we_o    = (state == S_NVWR);

  ////////////////////////////////////////////////////////////////////////
  // Frame intake, decode and execution
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state        <= S_BOOT;
      cnt          <= 4'h0;
      f_addr       <= 8'h00;
      f_ins        <= 8'h00;
      f_type       <= 8'h00;
      f_mot        <= 8'h00;
      f_val        <= 32'h0000_0000;
      sum          <= 8'h00;
      last         <= 5'h00;
      quiet        <= 1'b0;
      accu_o       <= 32'h0000_0000;
      xreg_o       <= 32'h0000_0000;
      nv_addr_o    <= 5'h00;
      nv_wdata_o   <= 32'h0000_0000;
      rep_valid_o  <= 1'b0;
      rep_status_o <= 8'h00;
      rep_instr_o  <= 8'h00;
      rep_value_o  <= 32'h0000_0000;
      for (i = 0; i <= 20; i = i + 1) begin
        coord[i] <= 32'h0000_0000;
      end
    end else begin
      rep_valid_o <= 1'b0;
      if (accu_wr_i && (state == S_RX)) begin
        accu_o <= accu_wr_data_i;
      end
      case (state)
        S_BOOT: begin
          nv_addr_o <= 5'h01;
          last      <= 5'h14;
          quiet     <= nv_keep_i;
          state     <= nv_keep_i ? S_NVRD : S_RX;
        end

        S_RX: begin
          if (take) begin
            cnt <= frame_end ? 4'h0 : pos + 4'h1;
            sum <= (pos == 4'h0) ? rx_data_i : sum + rx_data_i;
            case (pos)
              4'h0: f_addr <= rx_data_i;
              4'h1: f_ins <= rx_data_i;
              4'h2: f_type <= rx_data_i;
              4'h3: f_mot <= rx_data_i;
              4'h4, 4'h5, 4'h6, 4'h7: begin
                f_val <= {f_val[23:0], rx_data_i};
              end
              default: begin
              end
            endcase
          end
          if (frame_end && (f_addr == mod_addr_i)) begin
            rep_instr_o  <= f_ins;
            rep_status_o <= `CSX_ST_OK;
            rep_value_o  <= 32'h0000_0000;
            state        <= S_REPLY;
            if (rx_data_i != sum) begin
              rep_status_o <= `CSX_ST_BAD_SUM;
            end else begin
              case (f_ins)
                `CSX_INS_RD: begin
                  if (f_mot == `CSX_MOT_ALL) begin
                    if (f_type == 8'h00) begin
                      nv_addr_o <= 5'h01;
                      last      <= 5'h14;
                      state     <= S_NVRD;
                    end else if (one_ok) begin
                      nv_addr_o <= sel;
                      last      <= sel;
                      state     <= S_NVRD;
                    end else begin
                      rep_status_o <= `CSX_ST_BAD_VAL;
                    end
                  end else if (bad_sel) begin
                    rep_status_o <= `CSX_ST_BAD_VAL;
                  end else begin
                    rep_value_o <= coord[sel];
                    if (standalone_i) begin
                      accu_o <= coord[sel];
                    end
                  end
                end

                `CSX_INS_WR: begin
                  if (f_mot == `CSX_MOT_ALL) begin
                    if (f_type == 8'h00) begin
                      nv_addr_o <= 5'h01;
                      last      <= 5'h14;
                      state     <= S_NVLD;
                    end else if (one_ok) begin
                      nv_addr_o <= sel;
                      last      <= sel;
                      state     <= S_NVLD;
                    end else begin
                      rep_status_o <= `CSX_ST_BAD_VAL;
                    end
                  end else if (bad_sel) begin
                    rep_status_o <= `CSX_ST_BAD_VAL;
                  end else begin
                    coord[sel] <= f_val;
                    if (keep_nv) begin
                      nv_addr_o <= sel;
                      last      <= sel;
                      state     <= S_NVLD;
                    end
                  end
                end

                `CSX_INS_CAP: begin
                  if (bad_sel) begin
                    rep_status_o <= `CSX_ST_BAD_VAL;
                  end else begin
                    coord[sel]  <= act_pos_i;
                    rep_value_o <= act_pos_i;
                    if (keep_nv) begin
                      nv_addr_o <= sel;
                      last      <= sel;
                      state     <= S_NVLD;
                    end
                  end
                end

                `CSX_INS_ACO: begin
                  if (bad_sel) begin
                    rep_status_o <= `CSX_ST_BAD_VAL;
                  end else begin
                    coord[sel] <= accu_o;
                    if (keep_nv) begin
                      nv_addr_o <= sel;
                      last      <= sel;
                      state     <= S_NVLD;
                    end
                  end
                end

                `CSX_INS_ARITH: begin
                  accu_o       <= next_accu;
                  xreg_o       <= next_xreg;
                  rep_status_o <= next_status;
                end

                default: state <= S_RX;
              endcase
            end
          end
        end

        ////////////////////////////////////////////////////////////////////
        // Non-volatile copy loops
        S_NVRD: begin
          if (nv_ack_i) begin
            coord[nv_addr_o] <= nv_rdata_i;
            if (nv_addr_o == last) begin
              state <= quiet ? S_RX : S_REPLY;
              quiet <= 1'b0;
            end else begin
              nv_addr_o <= nv_addr_o + 5'h01;
            end
          end
        end

        S_NVLD: begin
          nv_wdata_o <= coord[nv_addr_o];
          state      <= S_NVWR;
        end

        S_NVWR: begin
          if (nv_ack_i) begin
            if (nv_addr_o == last) begin
              state <= S_REPLY;
            end else begin
              nv_addr_o <= nv_addr_o + 5'h01;
              state     <= S_NVLD;
            end
          end
        end

        S_REPLY: begin
          rep_valid_o <= ~standalone_i;
          state       <= S_RX;
        end

        default: state <= S_RX;
      endcase
    end
  end

endmodule // csx_core

// ---- rtl/csx_consts.vh ----
// Function
// - Coordinate read in standalone mode copies selected coordinate into accumulator.
// - Coordinate read in direct mode replies with value, accumulator untouched.
// - Storage setting picks working memory only or also non-volatile; default working.
// - Coordinate zero lives in working memory only, never non-volatile.
// - Read with coordinate 0, motor 255 restores coordinates 1..20 from non-volatile.
// - Read with motor 255, coordinate 1..20 restores only that one.
// - Capture command writes actual axis position into selected coordinate.
// - Accumulator-to-coordinate command writes accumulator into selected coordinate.
// - Direct mode replies status 100; read and capture return the value.
// - Arithmetic command uses auxiliary register operand; types 0-7 put the result into accumulator.
// - Types 0-4 add, subtract, multiply, divide, modulo with accumulator first.
// - Types 5-7 AND, OR, XOR accumulator with auxiliary register.
// - Type 8 inverts the auxiliary register.
// - Type 9 copies accumulator to auxiliary; type 10 swaps them.
// - Axis holds twenty-one position coordinates, 0..20; only 1..20 go to non-volatile.
// - Write with coordinate 0, motor 255 saves coordinates 1..20 to non-volatile.
`ifndef CSX_CONSTS_VH
`define CSX_CONSTS_VH

// Instructions
`define CSX_INS_WR      8'h1e
`define CSX_INS_RD      8'h1f
`define CSX_INS_CAP     8'h20
`define CSX_INS_ARITH   8'h21
`define CSX_INS_ACO     8'h27

// Field values
`define CSX_MOT_ALL     8'hff
`define CSX_COORD_MAX   8'h14
`define CSX_GP_STORE    8'h54
`define CSX_LAST_BYTE   4'h8

// Reply status
`define CSX_ST_OK       8'h64
`define CSX_ST_BAD_SUM  8'h01
`define CSX_ST_BAD_TYPE 8'h03
`define CSX_ST_BAD_VAL  8'h04

// Arithmetic types
`define CSX_OP_ADD      8'h00
`define CSX_OP_SUB      8'h01
`define CSX_OP_MUL      8'h02
`define CSX_OP_DIV      8'h03
`define CSX_OP_MOD      8'h04
`define CSX_OP_AND      8'h05
`define CSX_OP_OR       8'h06
`define CSX_OP_XOR      8'h07
`define CSX_OP_NOT      8'h08
`define CSX_OP_LOAD     8'h09
`define CSX_OP_SWAP     8'h0a

`endif

// ---- test/csx_core_properties.sv ----
`timescale 1ns/10ps
module csx_core_properties (
  input logic        sys_clk_i,
  input logic        resetn_i,
  input logic        standalone_i,
  input logic        rx_valid_i,
  input logic        accu_wr_i,
  input logic        rx_ready_o,
  input logic [31:0] accu_o,
  input logic [31:0] xreg_o,
  input logic        nv_req_o,
  input logic        nv_we_o,
  input logic [4:0]  nv_addr_o,
  input logic        nv_ack_i,
  input logic        rep_valid_o,
  input logic [7:0]  rep_status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_pulse;
    rep_valid_o ##1 !rep_valid_o;
  endsequence
  sequence s_wait;
    nv_req_o && !nv_ack_i;
  endsequence
  a_reply_single: assert property (
    rep_valid_o |-> s_pulse) else $error("reply pulse too long");
  a_reply_direct: assert property (
    rep_valid_o |-> !$past(standalone_i)) else $error("reply in standalone");
  a_reply_status: assert property (
    rep_valid_o |-> rep_status_o inside {8'h64, 8'h01, 8'h03, 8'h04})
    else $error("bad status code");
  a_reply_ready: assert property (
    rep_valid_o |-> rx_ready_o && !$past(rx_ready_o))
    else $error("reply outside reply state");
  a_nv_range: assert property (
    nv_req_o |-> nv_addr_o >= 5'h01 && nv_addr_o <= 5'h14)
    else $error("nv index out of range");
  a_nv_hold: assert property (
    s_wait |=> nv_req_o && $stable(nv_addr_o) && $stable(nv_we_o))
    else $error("nv request dropped");
  a_nv_busy: assert property (
    nv_req_o |-> !rx_ready_o && !rep_valid_o) else $error("busy overlap");
  a_accu_hold: assert property (
    rx_ready_o && !rx_valid_i && !accu_wr_i |=>
    $stable(accu_o) && $stable(xreg_o)) else $error("accu changed idle");
endmodule // csx_core_properties
bind csx_core csx_core_properties u_props (.sys_clk_i, .resetn_i,
  .standalone_i, .rx_valid_i, .accu_wr_i, .rx_ready_o, .accu_o, .xreg_o,
  .nv_req_o, .nv_we_o, .nv_addr_o, .nv_ack_i, .rep_valid_o, .rep_status_o);

// ---- test/csx_nv_model.sv ----
`timescale 1ns/10ps
module csx_nv_model (
  input  logic        clk_i,
  input  logic        resetn_i,
  input  logic [1:0]  dly_i,
  input  logic        req_i,
  input  logic        we_i,
  input  logic [4:0]  addr_i,
  input  logic [31:0] wdata_i,
  output logic        ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:31];
  logic [31:0] last;
  logic [1:0]  cnt;
  initial for (int i = 0; i < 32; i++) mem[i] = 32'h005e0000 + i;
  // Idle bus shows inverse of last word
  assign rdata_o = ack_o ? last : ~last;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      last <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o) begin
        if (cnt >= dly_i) begin
          ack_o <= 1'b1;
          cnt <= 2'h0;
          last <= mem[addr_i];
          if (we_i) mem[addr_i] <= wdata_i;
        end else
          cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // csx_nv_model

// ---- test/csx_core_bench.sv ----
`timescale 1ns/10ps
`include "csx_consts.vh"
module csx_core_bench;
  logic        sys_clk_i = 0, resetn_i = 0, standalone_i = 0, nv_keep_i = 0;
  logic        rx_valid_i = 0, rx_first_i = 0, accu_wr_i = 0;
  logic [7:0]  rx_data_i = 0;
  logic [31:0] act_pos_i = 0, accu_wr_data_i = 0, nv_rdata_i;
  logic [1:0]  dly = 0;
  wire         rx_ready_o, nv_req_o, nv_we_o, nv_ack_i, rep_valid_o;
  wire  [31:0] accu_o, xreg_o, nv_wdata_o, rep_value_o;
  wire  [4:0]  nv_addr_o;
  wire  [7:0]  rep_status_o, rep_instr_o;
  integer      num_errors = 0, check_count = 0, seed = 32'h6bff5fc0, n;
  logic [48:0] q [$];
  logic [31:0] a, b;
  logic [63:0] r;
  always #50 sys_clk_i = ~sys_clk_i;
  csx_core DUT (.sys_clk_i, .resetn_i, .mod_addr_i(8'h01), .standalone_i,
    .nv_keep_i, .rx_valid_i, .rx_first_i, .rx_data_i, .rx_ready_o,
    .act_pos_i, .accu_wr_i, .accu_wr_data_i, .accu_o, .xreg_o, .nv_req_o,
    .nv_we_o, .nv_addr_o, .nv_wdata_o, .nv_ack_i, .nv_rdata_i, .rep_valid_o,
    .rep_status_o, .rep_instr_o, .rep_value_o);
  csx_nv_model u_nv (.clk_i(sys_clk_i), .resetn_i, .dly_i(dly),
    .req_i(nv_req_o), .we_i(nv_we_o), .addr_i(nv_addr_o),
    .wdata_i(nv_wdata_o), .ack_o(nv_ack_i), .rdata_o(nv_rdata_i));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task hang(input integer k);
    if (k >= 400) begin
      num_errors++;
      close_out;
    end
  endtask
  // Reply checker, pops oldest note
  always @(negedge sys_clk_i) begin : rep_watch
    logic [48:0] nt;
    if (rep_valid_o === 1'b1) begin
      if (q.size() == 0) chk("spare reply", 32'h0, 32'h1);
      else begin
        nt = q.pop_front();
        chk("status", nt[39:32], rep_status_o);
        chk("instr", nt[48:41], rep_instr_o);
        if (nt[40]) chk("value", nt[31:0], rep_value_o);
      end
    end
  end
  task load(input logic [31:0] v);
    @(negedge sys_clk_i) accu_wr_i = 1;
    accu_wr_data_i = v;
    @(negedge sys_clk_i) accu_wr_i = 0;
  endtask
  task run(input logic [7:0] ins, ty, mo, input logic [31:0] v,
           input logic [7:0] st, input logic cv, input logic [31:0] ev,
           input logic [7:0] bad = 0);
    logic [71:0] f;
    f = {8'h01, ins, ty, mo, v, 8'h00};
    for (int i = 1; i < 9; i++) f[7:0] += f[8*i +: 8];
    f[7:0] ^= bad;
    dly = $random(seed);
    if (!standalone_i) q.push_back({ins, cv, st, ev});
    for (int i = 8; i >= 0; i--) begin
      @(negedge sys_clk_i) rx_valid_i = 1;
      rx_first_i = (i == 8);
      rx_data_i = f[8*i +: 8];
      for (n = 0; rx_ready_o !== 1'b1 && n < 400; n++) @(negedge sys_clk_i);
      hang(n);
    end
    @(negedge sys_clk_i) rx_valid_i = 0;
    for (n = 0; (q.size() || rx_ready_o !== 1'b1) && n < 400; n++)
      @(negedge sys_clk_i);
    hang(n);
  endtask
  function automatic logic [63:0] alu(input int t, input logic [31:0] a, b);
    case (t)
      0: return {b, a + b};
      1: return {b, a - b};
      2: return {b, a * b};
      3: return {b, $signed(a) / $signed(b)};
      4: return {b, $signed(a) % $signed(b)};
      5: return {b, a & b};
      6: return {b, a | b};
      7: return {b, a ^ b};
      8: return {~b, a};
      9: return {a, a};
      default: return {a, b};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge sys_clk_i);
    resetn_i = 1;
    a = $random(seed);
    act_pos_i = a;
    run(`CSX_INS_CAP, 3, 0, 0, `CSX_ST_OK, 1, a);
    run(`CSX_INS_RD, 3, 0, 0, `CSX_ST_OK, 1, a);
    chk("nv kept", 32'h005e0003, u_nv.mem[3]);
    b = $random(seed);
    load(b);
    run(`CSX_INS_ACO, 0, 0, 0, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_RD, 0, 0, 0, `CSX_ST_OK, 1, b);
    chk("accu", b, accu_o);
    standalone_i = 1;
    run(`CSX_INS_RD, 3, 0, 0, 0, 0, 0);
    chk("accu", a, accu_o);
    standalone_i = 0;
    $display("test coordinates done");
    run(`CSX_INS_RD, 0, 8'hff, 0, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_RD, 3, 0, 0, `CSX_ST_OK, 1, 32'h005e0003);
    run(`CSX_INS_RD, 0, 0, 0, `CSX_ST_OK, 1, b);
    u_nv.mem[5] = a;
    u_nv.mem[6] = a;
    run(`CSX_INS_RD, 5, 8'hff, 0, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_RD, 5, 0, 0, `CSX_ST_OK, 1, a);
    run(`CSX_INS_RD, 6, 0, 0, `CSX_ST_OK, 1, 32'h005e0006);
    run(`CSX_INS_WR, 7, 0, b, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_RD, 7, 0, 0, `CSX_ST_OK, 1, b);
    run(`CSX_INS_ACO, 2, 0, 0, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_WR, 0, 8'hff, 0, `CSX_ST_OK, 0, 0);
    chk("nv all", a, u_nv.mem[2]);
    chk("nv zero", 32'h005e0000, u_nv.mem[0]);
    nv_keep_i = 1;
    run(`CSX_INS_CAP, 4, 0, 0, `CSX_ST_OK, 1, a);
    chk("nv keep", a, u_nv.mem[4]);
    nv_keep_i = 0;
    $display("test storage done");
    nv_keep_i = 1;
    @(negedge sys_clk_i) resetn_i = 0;
    repeat (10) @(negedge sys_clk_i);
    resetn_i = 1;
    run(`CSX_INS_RD, 4, 0, 0, `CSX_ST_OK, 1, a);
    run(`CSX_INS_RD, 0, 0, 0, `CSX_ST_OK, 1, 0);
    nv_keep_i = 0;
    $display("test restart done");
    for (int t = 0; t <= 10; t++) begin
      a = $random(seed);
      b = $random(seed) | 32'h1;
      load(b);
      run(`CSX_INS_ARITH, `CSX_OP_LOAD, 0, 0, `CSX_ST_OK, 0, 0);
      load(a);
      run(`CSX_INS_ARITH, t, 0, 0, `CSX_ST_OK, 0, 0);
      r = alu(t, a, b);
      chk("accu", r[31:0], accu_o);
      chk("xreg", r[63:32], xreg_o);
    end
    $display("test arithmetic done");
    run(`CSX_INS_ARITH, 0, 0, 0, `CSX_ST_BAD_SUM, 0, 0, 8'h01);
    run(`CSX_INS_ARITH, 11, 0, 0, `CSX_ST_BAD_TYPE, 0, 0);
    load(0);
    run(`CSX_INS_ARITH, `CSX_OP_LOAD, 0, 0, `CSX_ST_OK, 0, 0);
    run(`CSX_INS_ARITH, `CSX_OP_DIV, 0, 0, `CSX_ST_BAD_VAL, 0, 0);
    run(`CSX_INS_ARITH, `CSX_OP_MOD, 0, 0, `CSX_ST_BAD_VAL, 0, 0);
    run(`CSX_INS_RD, 21, 0, 0, `CSX_ST_BAD_VAL, 0, 0);
    $display("test refusals done");
    close_out;
  end
endmodule // csx_core_bench
